/* logic/fdl_port_pkg.sv */
// Purpose: Shared constants and types for the legacy link byte port.
// Assumes: Two framers, an 8-bit register port and one 10 MHz clock.
// Notes: Framer A is index 0 and framer B is index 1 in every array.
`default_nettype none

package fdl_port_pkg;

  // Number of framers served by one port.
  localparam int FRAMERS = 2;

  // Register offsets on the parallel port, one entry per framer.
  localparam logic [7:0] RX_LINK_BYTE_OFFSET [FRAMERS] = '{8'h28, 8'hC8};
  localparam logic [7:0] RX_MATCH_BYTE_ONE_OFFSET [FRAMERS] = '{8'h29, 8'hC9};
  localparam logic [7:0] RX_MATCH_BYTE_TWO_OFFSET [FRAMERS] = '{8'h2A, 8'hCA};
  localparam logic [7:0] TX_LINK_BYTE_OFFSET [FRAMERS] = '{8'h7E, 8'hFE};

  // Reset value of every byte register and of the read data.
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Index of the last bit of a byte, counted from zero.
  localparam logic [2:0] LAST_BIT_INDEX = 3'h7;

  // Run of ones after which a zero is stuffed or removed.
  localparam logic [2:0] STUFF_RUN_ONES = 3'h5;

  // Ones counter ceiling; a run of six or more is a flag or abort.
  localparam logic [2:0] ONES_SATURATE = 3'h6;

  // Which register an address selects within one framer.
  typedef enum logic [2:0] {
    KIND_NONE      = 3'b000,
    KIND_RX_BYTE   = 3'b001,
    KIND_MATCH_ONE = 3'b010,
    KIND_MATCH_TWO = 3'b011,
    KIND_TX_BYTE   = 3'b100
  } reg_kind_type;

endpackage : fdl_port_pkg

`default_nettype wire

/* logic/rx_link_deframer.sv */
// Purpose: Collects received link bits into bytes and compares them.
// Assumes: strobe_in marks one cycle per link bit position.
// Notes: Pulses on full_out and match_out last one clock.
`default_nettype none

module rx_link_deframer
  import fdl_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic bit_in,
  input wire logic strobe_in,
  input wire logic destuff_en_in,
  input wire logic [7:0] match_one_in,
  input wire logic [7:0] match_two_in,
  output wire logic [7:0] byte_out,
  output wire logic full_out,
  output wire logic match_out
);

  logic [7:0] shift_r;   // Bits gathered so far, newest at the top.
  logic [2:0] count_r;   // Bits gathered in the current byte.
  logic [2:0] ones_r;    // Ones seen in a row, saturating at six.
  logic [7:0] byte_r;    // Last completed byte.
  logic full_r;          // One-cycle pulse when a byte completes.
  logic match_r;         // One-cycle pulse when that byte matches.

  // A zero after exactly five ones is a stuffed bit; six or more ones keep it.
  wire drop_w = destuff_en_in && !bit_in && (ones_r == STUFF_RUN_ONES); // [R7] [R8]
  wire [2:0] ones_nxt = !bit_in ? 3'h0 :
                        (ones_r == ONES_SATURATE) ? ones_r : ones_r + 3'h1;
  // New bits enter at the top so the first one ends in the lowest bit.
  wire [7:0] shift_nxt = {bit_in, shift_r[7:1]}; // [R1] [R10]
  wire take_w = strobe_in && !drop_w;
  wire last_w = take_w && (count_r == LAST_BIT_INDEX);

  // Shift and count on every accepted bit; compare on the eighth one.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shift_r <= BYTE_RESET;
      count_r <= 3'h0;
      ones_r <= 3'h0;
      byte_r <= BYTE_RESET;
      full_r <= 1'b0;
      match_r <= 1'b0;
    end else begin
      full_r <= last_w; // [R2]
      match_r <= last_w && (shift_nxt == match_one_in || shift_nxt == match_two_in); // [R5]
      if (strobe_in) begin
        ones_r <= ones_nxt;
      end
      if (take_w) begin
        shift_r <= shift_nxt;
        count_r <= count_r + 3'h1;
      end
      // An unread byte is simply overwritten by the next one.
      if (last_w) begin
        byte_r <= shift_nxt; // [R4]
      end
    end
  end

  assign byte_out = byte_r;
  assign full_out = full_r;
  assign match_out = match_r;

endmodule // rx_link_deframer

`default_nettype wire

/* logic/tx_link_serializer.sv */
// Purpose: Sends a host byte, lowest bit first, into link bit positions.
// Assumes: slot_in marks the cycle in which the framer takes bit_out.
// Notes: The byte is reloaded at each byte end, or rotates with boundary loading, so an unchanged byte is simply sent again.
`default_nettype none

module tx_link_serializer
  import fdl_port_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic slot_in,
  input wire logic multiframe_in,
  input wire logic stuff_en_in,
  input wire logic mf_load_en_in,
  input wire logic [7:0] byte_in,
  output wire logic bit_out,
  output wire logic done_out
);

  logic [7:0] shift_r, shift_nxt;  // Byte being sent, next bit at the bottom.
  logic [2:0] count_r, count_nxt;  // Data bits sent from this byte.
  logic [2:0] ones_r, ones_nxt;    // Ones sent in a row.
  logic stuff_r, stuff_nxt;        // The bit on offer is a stuffed zero.
  logic bit_r, bit_nxt;            // Bit offered to the framer.
  logic done_r, done_nxt;          // One-cycle pulse after the eighth bit.

  wire [7:0] rotated_w = {shift_r[0], shift_r[7:1]};
  wire [2:0] ones_up_w = shift_r[0] ? ones_r + 3'h1 : 3'h0;
  wire last_w = (count_r == LAST_BIT_INDEX);

  // Next state of the sender for the current slot and boundary.
  always_comb begin
    shift_nxt = shift_r;
    count_nxt = count_r;
    ones_nxt = ones_r;
    stuff_nxt = stuff_r;
    bit_nxt = bit_r;
    done_nxt = 1'b0;
    if (slot_in) begin
      if (stuff_r) begin
        // The stuffed zero went out; the held data bit is offered now.
        stuff_nxt = 1'b0;
        ones_nxt = 3'h0;
        bit_nxt = shift_r[0];
      end else begin
        count_nxt = count_r + 3'h1;
        ones_nxt = ones_up_w;
        done_nxt = last_w; // [R12]
        // Without boundary loading a fresh byte is taken at each byte end.
        shift_nxt = (last_w && !mf_load_en_in) ? byte_in : rotated_w; // [R11] [R14]
        stuff_nxt = stuff_en_in && (ones_up_w == STUFF_RUN_ONES); // [R15]
        bit_nxt = stuff_nxt ? 1'b0 : shift_nxt[0];
      end
    end
    if (multiframe_in && mf_load_en_in) begin
      // Boundary loading restarts the byte at the multiframe edge.
      shift_nxt = byte_in; // [R19]
      count_nxt = 3'h0;
      bit_nxt = stuff_nxt ? 1'b0 : byte_in[0];
    end
  end

  // State registers of the sender.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shift_r <= BYTE_RESET;
      count_r <= 3'h0;
      ones_r <= 3'h0;
      stuff_r <= 1'b0;
      bit_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      count_r <= count_nxt;
      ones_r <= ones_nxt;
      stuff_r <= stuff_nxt;
      bit_r <= bit_nxt;
      done_r <= done_nxt;
    end
  end

  assign bit_out = bit_r;
  assign done_out = done_r;

endmodule // tx_link_serializer

`default_nettype wire

/* logic/legacy_fdl_byte_port.sv */
// Purpose: Byte-wide access to the data link of two framers for a host.
// Assumes: Host strobes are synchronous to CLK_IN; one strobe per access.
// Notes: Status flags, masks and controls are plain pins, not registers.
`default_nettype none

// How it works
// [R1] Received link bits shift into a byte.
// [R2] A full byte raises the buffer full flag.
// [R3] Unmasked full flag pulls the interrupt low.
// [R4] Host reads within 2 ms or loses it.
// [R5] Byte equal to a match byte sets flag.
// [R6] Unmasked match flag pulls the interrupt low.
// [R7] Destuffing removes zero after five ones.
// [R8] Six or more ones keep the zero.
// [R9] Host keeps destuffing on while extracting.
// [R10] First received bit lands in bit zero.
// [R11] Transmit byte goes out lowest bit first.
// [R12] Eight bits sent raise the empty flag.
// [R13] Unmasked empty flag pulls the interrupt low.
// [R14] Unrefreshed transmit byte is sent again.
// [R15] Stuffing inserts zero after five ones.
// [R16] One transmit source; receive shared freely.
// [R17] Host writes 1Ch for the Fs pattern.
// [R18] Fs select low takes Fs from byte.
// [R19] Boundary loading waits for multiframe edges.
// [R20] Flags latch until acknowledged; interrupt follows.
module legacy_fdl_byte_port
  import fdl_port_pkg::*;
(
  // Clock and synchronous reset.
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // Parallel register port.
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WR_DATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output wire logic [7:0] RD_DATA_OUT,
  // Receive link bits from each framer.
  input wire logic [FRAMERS-1:0] RX_LINK_BIT_IN,
  input wire logic [FRAMERS-1:0] RX_LINK_STROBE_IN,
  input wire logic [FRAMERS-1:0] RX_ZERO_DESTUFF_ENABLE_IN,
  // Transmit link slots and controls for each framer.
  input wire logic [FRAMERS-1:0] TX_LINK_SLOT_IN,
  input wire logic [FRAMERS-1:0] MULTIFRAME_IN,
  input wire logic [FRAMERS-1:0] TX_ZERO_STUFF_ENABLE_IN,
  input wire logic [FRAMERS-1:0] MULTIFRAME_LOAD_ENABLE_IN,
  input wire logic [FRAMERS-1:0] D4_MODE_IN,
  input wire logic [FRAMERS-1:0] FS_SOURCE_SELECT_IN,
  input wire logic [FRAMERS-1:0] TX_LEGACY_SOURCE_IN,
  output wire logic [FRAMERS-1:0] TX_LINK_BIT_OUT,
  output wire logic [FRAMERS-1:0] TX_LINK_DRIVE_OUT,
  // Interrupt masks, one bit per framer.
  input wire logic [FRAMERS-1:0] RX_FULL_IRQ_MASK_IN,
  input wire logic [FRAMERS-1:0] RX_MATCH_IRQ_MASK_IN,
  input wire logic [FRAMERS-1:0] TX_EMPTY_IRQ_MASK_IN,
  // Flag acknowledges from the host, one bit per framer.
  input wire logic [FRAMERS-1:0] RX_FULL_ACK_IN,
  input wire logic [FRAMERS-1:0] RX_MATCH_ACK_IN,
  input wire logic [FRAMERS-1:0] TX_EMPTY_ACK_IN,
  // Latched status flags and the shared interrupt.
  output wire logic [FRAMERS-1:0] RX_BUFFER_FULL_FLAG_OUT,
  output wire logic [FRAMERS-1:0] RX_MATCH_FLAG_OUT,
  output wire logic [FRAMERS-1:0] TX_BUFFER_EMPTY_FLAG_OUT,
  output wire logic INT_N_OUT
);

  // Maps an address onto one framer's registers, given that framer's offsets.
  function automatic reg_kind_type decode_kind(
    input logic [7:0] addr,
    input logic [7:0] rx_off,
    input logic [7:0] one_off,
    input logic [7:0] two_off,
    input logic [7:0] tx_off
  );
    reg_kind_type kind;
    kind = KIND_NONE;
    if (addr == rx_off) begin
      kind = KIND_RX_BYTE;
    end else if (addr == one_off) begin
      kind = KIND_MATCH_ONE;
    end else if (addr == two_off) begin
      kind = KIND_MATCH_TWO;
    end else if (addr == tx_off) begin
      kind = KIND_TX_BYTE;
    end
    return kind;
  endfunction

  // Register kind selected by the address, per framer.
  reg_kind_type kind_w [FRAMERS];

  // Host-written byte registers, per framer.
  logic [7:0] match_one_r [FRAMERS];
  logic [7:0] match_two_r [FRAMERS];
  logic [7:0] tx_byte_r [FRAMERS];

  // Received byte held by each deframer.
  logic [7:0] rx_byte_w [FRAMERS];

  // Per-framer read data; only the addressed framer gives a non-zero value.
  logic [7:0] rd_part_w [FRAMERS];

  // Event pulses from the receive and transmit sides.
  logic [FRAMERS-1:0] rx_full_pulse_w;
  logic [FRAMERS-1:0] rx_match_pulse_w;
  logic [FRAMERS-1:0] tx_done_pulse_w;

  // Transmit bit offered by each serializer.
  logic [FRAMERS-1:0] tx_bit_w;

  // Slots that the legacy serializer is allowed to use.
  logic [FRAMERS-1:0] tx_slot_w;

  // Latched flags.
  logic [FRAMERS-1:0] rx_full_flag_r;
  logic [FRAMERS-1:0] rx_match_flag_r;
  logic [FRAMERS-1:0] tx_empty_flag_r;

  // Whether each legacy transmit path owns its link positions.
  logic [FRAMERS-1:0] tx_drive_r;
  logic [FRAMERS-1:0] tx_drive_w;

  // Read data and interrupt registers.
  logic [7:0] rd_data_r;
  logic int_n_r;

  // Combined read value over both framers.
  wire [7:0] rd_value_w = rd_part_w[0] | rd_part_w[1];

  // Any flag whose mask bit is set asks for the interrupt.
  wire irq_any_w = |((rx_full_flag_r & RX_FULL_IRQ_MASK_IN) |   // [R3]
                     (rx_match_flag_r & RX_MATCH_IRQ_MASK_IN) | // [R6]
                     (tx_empty_flag_r & TX_EMPTY_IRQ_MASK_IN)); // [R13]

  genvar f;
  generate
    for (f = 0; f < FRAMERS; f = f + 1) begin : g_framer

      // Address decode for this framer.
      assign kind_w[f] = decode_kind(ADDR_IN, RX_LINK_BYTE_OFFSET[f],
                                     RX_MATCH_BYTE_ONE_OFFSET[f],
                                     RX_MATCH_BYTE_TWO_OFFSET[f],
                                     TX_LINK_BYTE_OFFSET[f]);

      // Write strobes; the received byte is read-only, so writes to it vanish.
      wire wr_one_w = WR_IN && (kind_w[f] == KIND_MATCH_ONE);
      wire wr_two_w = WR_IN && (kind_w[f] == KIND_MATCH_TWO);
      wire wr_tx_w = WR_IN && (kind_w[f] == KIND_TX_BYTE);

      // Read selection for this framer; unmapped addresses give zero.
      assign rd_part_w[f] =
        (kind_w[f] == KIND_RX_BYTE) ? rx_byte_w[f] :
        (kind_w[f] == KIND_MATCH_ONE) ? match_one_r[f] :
        (kind_w[f] == KIND_MATCH_TWO) ? match_two_r[f] :
        (kind_w[f] == KIND_TX_BYTE) ? tx_byte_r[f] : BYTE_RESET;

      // The legacy path drives the link only when it is the chosen source.
      // In D4 the Fs positions come from this byte only when the select is low.
      assign tx_drive_w[f] = TX_LEGACY_SOURCE_IN[f] &&
                             (!D4_MODE_IN[f] || !FS_SOURCE_SELECT_IN[f]); // [R16] [R18]

      // Slots are consumed only while this path drives, so another source
      // can own the link without disturbing the byte position here.
      assign tx_slot_w[f] = TX_LINK_SLOT_IN[f] && tx_drive_r[f]; // [R16]

      // Host-written registers; the Fs pattern value is the host's to write.
      always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
          match_one_r[f] <= BYTE_RESET;
          match_two_r[f] <= BYTE_RESET;
          tx_byte_r[f] <= BYTE_RESET;
        end else begin
          if (wr_one_w) begin
            match_one_r[f] <= WR_DATA_IN;
          end
          if (wr_two_w) begin
            match_two_r[f] <= WR_DATA_IN;
          end
          if (wr_tx_w) begin
            tx_byte_r[f] <= WR_DATA_IN; // [R17]
          end
        end
      end

      // Source ownership is registered so the drive pin comes from a flop.
      always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
          tx_drive_r[f] <= 1'b0;
        end else begin
          tx_drive_r[f] <= tx_drive_w[f];
        end
      end

      // Receive side runs whatever the transmit source is, so the newer
      // controller and this path can both listen to the same link.
      rx_link_deframer u_rx (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .bit_in(RX_LINK_BIT_IN[f]),
        .strobe_in(RX_LINK_STROBE_IN[f]), // [R1]
        .destuff_en_in(RX_ZERO_DESTUFF_ENABLE_IN[f]), // [R7]
        .match_one_in(match_one_r[f]),
        .match_two_in(match_two_r[f]),
        .byte_out(rx_byte_w[f]),
        .full_out(rx_full_pulse_w[f]),
        .match_out(rx_match_pulse_w[f])
      );

      // Transmit side, fed from the host byte.
      tx_link_serializer u_tx (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .slot_in(tx_slot_w[f]),
        .multiframe_in(MULTIFRAME_IN[f]),
        .stuff_en_in(TX_ZERO_STUFF_ENABLE_IN[f]), // [R15]
        .mf_load_en_in(MULTIFRAME_LOAD_ENABLE_IN[f]), // [R19]
        .byte_in(tx_byte_r[f]), // [R11]
        .bit_out(tx_bit_w[f]),
        .done_out(tx_done_pulse_w[f])
      );

    end
  endgenerate

  // Flags latch on their event and clear on acknowledge; an event in the
  // same cycle as its acknowledge wins, so no byte event is ever missed.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      rx_full_flag_r <= '0;
      rx_match_flag_r <= '0;
      tx_empty_flag_r <= '0;
    end else begin
      rx_full_flag_r <= rx_full_pulse_w | (rx_full_flag_r & ~RX_FULL_ACK_IN); // [R2] [R20]
      rx_match_flag_r <= rx_match_pulse_w | (rx_match_flag_r & ~RX_MATCH_ACK_IN); // [R5] [R20]
      tx_empty_flag_r <= tx_done_pulse_w | (tx_empty_flag_r & ~TX_EMPTY_ACK_IN); // [R12] [R20]
    end
  end

  // The interrupt is registered from the flags, so it trails them by one
  // clock; it stays low as long as any unmasked flag stays set.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      int_n_r <= 1'b1;
    end else begin
      int_n_r <= !irq_any_w; // [R3] [R6] [R13] [R20]
    end
  end

  // Read data is captured on the read strobe and held until the next one.
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      rd_data_r <= BYTE_RESET;
    end else if (RD_IN) begin
      rd_data_r <= rd_value_w;
    end
  end

  // Outputs, each straight from a flip-flop.
  assign RD_DATA_OUT = rd_data_r;
  assign TX_LINK_BIT_OUT = tx_bit_w;
  assign TX_LINK_DRIVE_OUT = tx_drive_r;
  assign RX_BUFFER_FULL_FLAG_OUT = rx_full_flag_r;
  assign RX_MATCH_FLAG_OUT = rx_match_flag_r;
  assign TX_BUFFER_EMPTY_FLAG_OUT = tx_empty_flag_r;
  assign INT_N_OUT = int_n_r;

endmodule // legacy_fdl_byte_port

`default_nettype wire

/* sim/fdl_port_sva.sv */
// Purpose: Port timing checks for the legacy link byte port.
// Assumes: Framer A is watched closely; framer B shares the same logic.
// Notes: Reset is held at least three edges, so $past never sees stale flags.
`default_nettype none

module fdl_port_sva
  import fdl_port_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RD_DATA_OUT,
  input wire logic [FRAMERS-1:0] RX_LINK_STROBE_IN,
  input wire logic [FRAMERS-1:0] TX_LINK_SLOT_IN,
  input wire logic [FRAMERS-1:0] MULTIFRAME_IN,
  input wire logic [FRAMERS-1:0] TX_LEGACY_SOURCE_IN,
  input wire logic [FRAMERS-1:0] TX_LINK_BIT_OUT,
  input wire logic [FRAMERS-1:0] TX_LINK_DRIVE_OUT,
  input wire logic [FRAMERS-1:0] RX_FULL_IRQ_MASK_IN,
  input wire logic [FRAMERS-1:0] RX_MATCH_IRQ_MASK_IN,
  input wire logic [FRAMERS-1:0] TX_EMPTY_IRQ_MASK_IN,
  input wire logic [FRAMERS-1:0] RX_FULL_ACK_IN,
  input wire logic [FRAMERS-1:0] RX_BUFFER_FULL_FLAG_OUT,
  input wire logic [FRAMERS-1:0] RX_MATCH_FLAG_OUT,
  input wire logic [FRAMERS-1:0] TX_BUFFER_EMPTY_FLAG_OUT,
  input wire logic INT_N_OUT
);
  timeunit 1ns;
  timeprecision 1ns;

  // High while any flag is set with its mask on.
  wire logic irq_want = |((RX_BUFFER_FULL_FLAG_OUT & RX_FULL_IRQ_MASK_IN)
    | (RX_MATCH_FLAG_OUT & RX_MATCH_IRQ_MASK_IN)
    | (TX_BUFFER_EMPTY_FLAG_OUT & TX_EMPTY_IRQ_MASK_IN));

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RESET_IN);

  AST_INT_FOLLOWS: assert property (
    INT_N_OUT == !$past(irq_want)) else $error("interrupt does not follow flags");
  AST_FULL_LATCH: assert property (
    $past(RX_BUFFER_FULL_FLAG_OUT[0]) && !$past(RX_FULL_ACK_IN[0])
    |-> RX_BUFFER_FULL_FLAG_OUT[0]) else $error("full flag dropped without ack");
  AST_FULL_CAUSE: assert property (
    $rose(RX_BUFFER_FULL_FLAG_OUT[0]) |-> $past(RX_LINK_STROBE_IN[0], 2))
    else $error("full flag rose without a bit two edges before");
  AST_MATCH_CAUSE: assert property (
    $rose(RX_MATCH_FLAG_OUT[0]) |-> $past(RX_LINK_STROBE_IN[0], 2))
    else $error("match flag rose without a bit two edges before");
  AST_EMPTY_CAUSE: assert property (
    $rose(TX_BUFFER_EMPTY_FLAG_OUT[0])
    |-> $past(TX_LINK_SLOT_IN[0], 2) && $past(TX_LINK_DRIVE_OUT[0], 2))
    else $error("empty flag rose without a taken slot");
  AST_DRIVE_SOURCE: assert property (
    !$past(TX_LEGACY_SOURCE_IN[0]) |-> !TX_LINK_DRIVE_OUT[0])
    else $error("link driven while another source is chosen");
  AST_BIT_STILL: assert property (
    TX_LINK_DRIVE_OUT[0] && !$past(TX_LINK_SLOT_IN[0]) && !$past(MULTIFRAME_IN[0])
    |-> $stable(TX_LINK_BIT_OUT[0])) else $error("link bit moved without a slot");
  AST_RD_HOLDS: assert property (
    !$past(RD_IN) |-> $stable(RD_DATA_OUT)) else $error("read data moved without a read");

  // Main scenarios: a byte in, a match, a byte out.
  COV_FULL: cover property ($rose(RX_BUFFER_FULL_FLAG_OUT[0]));
  COV_MATCH: cover property ($rose(RX_MATCH_FLAG_OUT[0]));
  COV_EMPTY: cover property ($rose(TX_BUFFER_EMPTY_FLAG_OUT[0]));
endmodule // fdl_port_sva

bind legacy_fdl_byte_port fdl_port_sva sva_u (
  .CLK_IN(CLK_IN),
  .RESET_IN(RESET_IN),
  .RD_IN(RD_IN),
  .RD_DATA_OUT(RD_DATA_OUT),
  .RX_LINK_STROBE_IN(RX_LINK_STROBE_IN),
  .TX_LINK_SLOT_IN(TX_LINK_SLOT_IN),
  .MULTIFRAME_IN(MULTIFRAME_IN),
  .TX_LEGACY_SOURCE_IN(TX_LEGACY_SOURCE_IN),
  .TX_LINK_BIT_OUT(TX_LINK_BIT_OUT),
  .TX_LINK_DRIVE_OUT(TX_LINK_DRIVE_OUT),
  .RX_FULL_IRQ_MASK_IN(RX_FULL_IRQ_MASK_IN),
  .RX_MATCH_IRQ_MASK_IN(RX_MATCH_IRQ_MASK_IN),
  .TX_EMPTY_IRQ_MASK_IN(TX_EMPTY_IRQ_MASK_IN),
  .RX_FULL_ACK_IN(RX_FULL_ACK_IN),
  .RX_BUFFER_FULL_FLAG_OUT(RX_BUFFER_FULL_FLAG_OUT),
  .RX_MATCH_FLAG_OUT(RX_MATCH_FLAG_OUT),
  .TX_BUFFER_EMPTY_FLAG_OUT(TX_BUFFER_EMPTY_FLAG_OUT),
  .INT_N_OUT(INT_N_OUT)
);

`default_nettype wire

/* sim/host_model.sv */
// Purpose: Host side of the register port, one access at a time.
// Assumes: Outputs change just after a clock edge.
// Notes: Released lines show the inverse of their last value.
`default_nettype none

module host_model (
  input wire logic clk_in,
  input wire logic [7:0] rd_data_in,
  output var logic [7:0] addr_out,
  output var logic [7:0] wr_data_out,
  output var logic wr_out,
  output var logic rd_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // Quiet bus at time zero.
  initial begin
    addr_out = 8'h00;
    wr_data_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end

  // One write strobe, then the lines are scrambled so stale data cannot help.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wr_data_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wr_data_out <= ~d;
  endtask

  // Reads at once, well inside the time before the next byte lands.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask
endmodule // host_model

`default_nettype wire

/* sim/testbench.sv */
// Purpose: Self-checking bench for the legacy link byte port.
// Assumes: One 10 MHz clock; framer A carries the transmit tests.
// Notes: Random bytes come from a fixed seed, so every run repeats.
`default_nettype none

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench
  import fdl_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] rbit = 2'h0, strobe = 2'h0, destuff = 2'h0, slot = 2'h0, mframe = 2'h0;
  logic [1:0] stuff = 2'h0, mfload = 2'h0, d4 = 2'h0, fssel = 2'h0, src = 2'h3;
  logic [1:0] m_full = 2'h0, m_match = 2'h0, m_empty = 2'h0, ack = 2'h0;
  wire logic [7:0] addr, wdata, rdata;
  wire logic wr, rd, int_n;
  wire logic [1:0] txbit, drive, f_full, f_match, f_empty;
  int error_cnt = 0;
  int n_checks = 0;
  int f;
  logic [7:0] b, got;
  logic [15:0] cap;
  // Receive streams, first bit in bit zero, with their lengths.
  logic [15:0] tbl [2] = '{16'h009F, 16'h00BF};
  int tn [2] = '{9, 8};

  // Free-running clock.
  always #50 clk = ~clk;

  legacy_fdl_byte_port dut_u (
    .CLK_IN(clk),
    .RESET_IN(rst),
    .ADDR_IN(addr),
    .WR_DATA_IN(wdata),
    .WR_IN(wr),
    .RD_IN(rd),
    .RD_DATA_OUT(rdata),
    .RX_LINK_BIT_IN(rbit),
    .RX_LINK_STROBE_IN(strobe),
    .RX_ZERO_DESTUFF_ENABLE_IN(destuff),
    .TX_LINK_SLOT_IN(slot),
    .MULTIFRAME_IN(mframe),
    .TX_ZERO_STUFF_ENABLE_IN(stuff),
    .MULTIFRAME_LOAD_ENABLE_IN(mfload),
    .D4_MODE_IN(d4),
    .FS_SOURCE_SELECT_IN(fssel),
    .TX_LEGACY_SOURCE_IN(src),
    .TX_LINK_BIT_OUT(txbit),
    .TX_LINK_DRIVE_OUT(drive),
    .RX_FULL_IRQ_MASK_IN(m_full),
    .RX_MATCH_IRQ_MASK_IN(m_match),
    .TX_EMPTY_IRQ_MASK_IN(m_empty),
    .RX_FULL_ACK_IN(ack),
    .RX_MATCH_ACK_IN(ack),
    .TX_EMPTY_ACK_IN(ack),
    .RX_BUFFER_FULL_FLAG_OUT(f_full),
    .RX_MATCH_FLAG_OUT(f_match),
    .TX_BUFFER_EMPTY_FLAG_OUT(f_empty),
    .INT_N_OUT(int_n)
  );

  host_model host_u (
    .clk_in(clk),
    .rd_data_in(rdata),
    .addr_out(addr),
    .wr_data_out(wdata),
    .wr_out(wr),
    .rd_out(rd)
  );

  // Byte kept from a stream, dropping a zero after exactly five ones when enabled.
  function automatic logic [7:0] pack8(input logic [15:0] s, input int n, input logic ds);
    logic [7:0] r;
    int k;
    int ones;
    r = 8'h00;
    k = 0;
    ones = 0;
    for (int i = 0; i < n; i++) begin
      if (!(ds && !s[i] && ones == 5)) begin
        if (k < 8) r[k] = s[i];
        k++;
      end
      ones = s[i] ? ones + 1 : 0;
    end
    return r;
  endfunction

  // Back-to-back strobes, then time for the flags and the interrupt.
  task rx_bits(input int fr, input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      strobe[fr] <= 1'b1;
      rbit[fr] <= v[i];
    end
    @(posedge clk);
    strobe[fr] <= 1'b0;
    rbit[fr] <= ~v[n-1];
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // Offers slots and records the bit offered in each.
  task tx_take(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      slot[0] <= 1'b1;
      @(negedge clk);
      cap[i] = txbit[0];
      @(posedge clk);
      slot[0] <= 1'b0;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  // Clears every flag of both framers.
  task ack_all();
    @(posedge clk);
    ack <= 2'h3;
    @(posedge clk);
    ack <= 2'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need a few hundred cycles.
  initial begin
    #2000000;
    error_cnt++;
    results();
  end

  initial begin
    b = 8'($urandom(32'h9EF0));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    host_u.rd(8'h00, got);
    `CHK(got, BYTE_RESET)
    `CHK({int_n, drive}, 3'h7)
    for (int i = 0; i < FRAMERS; i++) begin
      b = 8'($urandom);
      host_u.wr(TX_LINK_BYTE_OFFSET[i], b);
      host_u.rd(TX_LINK_BYTE_OFFSET[i], got);
      `CHK(got, b)
      host_u.wr(RX_LINK_BYTE_OFFSET[i], b);
      host_u.rd(RX_LINK_BYTE_OFFSET[i], got);
      `CHK(got, BYTE_RESET)
    end
    $display("test regs done");
    for (int i = 0; i < 4; i++) begin
      f = i % 2;
      b = 8'($urandom);
      {m_full, m_match, m_empty} <= 6'($urandom);
      host_u.wr(i < 2 ? RX_MATCH_BYTE_ONE_OFFSET[f] : RX_MATCH_BYTE_TWO_OFFSET[f], b);
      rx_bits(f, {8'h00, b}, 8);
      `CHK({f_full[f], f_match[f]}, 2'h3)
      `CHK(int_n, ~(m_full[f] | m_match[f]))
      host_u.rd(RX_LINK_BYTE_OFFSET[f], got);
      `CHK(got, b)
      ack_all();
      `CHK({int_n, f_full[f], f_match[f]}, 3'h4)
    end
    rx_bits(1, {8'h00, ~b}, 8);
    `CHK(f_match[1], 1'b0)
    $display("test rx done");
    @(posedge clk);
    rst <= 1'b1;
    destuff <= 2'h3;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      rx_bits(0, tbl[i], tn[i]);
      host_u.rd(RX_LINK_BYTE_OFFSET[0], got);
      `CHK(got, pack8(tbl[i], tn[i], 1'b1))
      ack_all();
    end
    $display("test destuff done");
    b = 8'($urandom);
    host_u.wr(TX_LINK_BYTE_OFFSET[0], b);
    tx_take(8);
    `CHK(cap[7:0], BYTE_RESET)
    `CHK({int_n, f_empty[0]}, {~m_empty[0], 1'b1})
    ack_all();
    for (int i = 0; i < 2; i++) begin
      tx_take(8);
      `CHK(cap[7:0], b)
    end
    host_u.wr(TX_LINK_BYTE_OFFSET[0], 8'h00);
    tx_take(8);
    stuff <= 2'h1;
    host_u.wr(TX_LINK_BYTE_OFFSET[0], 8'hFF);
    tx_take(8);
    tx_take(6);
    `CHK(cap[5:0], 6'h1F)
    stuff <= 2'h0;
    mfload <= 2'h1;
    d4 <= 2'h1;
    host_u.wr(TX_LINK_BYTE_OFFSET[0], 8'h1C);
    @(posedge clk);
    mframe <= 2'h1;
    @(posedge clk);
    mframe <= 2'h0;
    tx_take(8);
    `CHK(cap[7:0], 8'h1C)
    src <= 2'h2;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(drive, 2'h2)
    @(posedge clk);
    {src, fssel} <= 4'hF;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK(drive, 2'h2)
    $display("test tx done");
    results();
  end
endmodule // testbench

`default_nettype wire
